// ### shared/lcdc_pkg.sv
// What this block does
// - Answer only address 0111000 or 0111001, low bit equals strap
// - Strap mismatch: ignore whole transfer until START
// - Matching-strap devices all acknowledge address together
// - Command bit 7 set: another command follows
// - All matching devices acknowledge every command byte
// - Display byte stored at pointer, pointer then advances
// - Only subaddress-counter match acknowledges display bytes
// - Mode-set command carries power, enable, bias, drive mode
// - Drive mode: 01 static, 10 1:2, 11 1:3, 00 1:4
// - Bias bit: zero one-third, one one-half
// - Enable bit: zero blanks, one shows display
// - Power bit: zero normal, one power saving
// - Bit 6 clear loads six-bit data pointer
// - Device-select loads three-bit subaddress counter
// - Bank-select sets input and output RAM bank
// - Bank-select ignored in 1:3 and 1:4 modes
// - Blink command sets blink rate, 00 off
// - Blink bit 2 selects alternate-bank blinking
// - Controller applies commands, fills RAM in order
// - Subaddress mismatch: no write, pointer still advances
// - Pointer overflow increments subaddress counter
// - Power saving: hold clock low while busy
//
// Purpose: constants and types of the serial command decoder
// Assumes: one display byte carries eight RAM bits
// Notes: command fields are named by bit position
package lcdc_pkg;

  // ----------------------------------------------------------------
  // bus addressing and RAM geometry
  // ----------------------------------------------------------------
  localparam logic [5:0] SLAVE_ADDR_TOP = 6'h1c; // upper six address bits
  localparam int unsigned RAM_DEPTH = 40;
  localparam logic [5:0] LAST_LOC = 6'h27;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int CONT_BIT = 7;
  localparam int CLASS_BIT = 6;
  localparam int OPC_TOP = 6;
  localparam int PWR_BIT = 4;
  localparam int EN_BIT = 3;
  localparam int BIAS_BIT = 2;
  localparam int ALT_BIT = 2;
  localparam int IN_BANK_BIT = 1;
  localparam int OUT_BANK_BIT = 0;
  localparam logic [1:0] OPC_MODE_SET = 2'h2; // bits 6:5
  localparam logic [3:0] OPC_DEV_SEL = 4'hc; // bits 6:3
  localparam logic [4:0] OPC_BANK = 5'h1e; // bits 6:2
  localparam logic [3:0] OPC_BLINK = 4'he; // bits 6:3

  // ----------------------------------------------------------------
  // drive modes and banks
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_DUPLEX = 2'h2;
  localparam logic [1:0] MODE_TRIPLEX = 2'h3;
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] HI_BANK_BASE = 2'h2;

  typedef struct packed {
    logic power_saving_sel;
    logic display_en;
    logic bias_half;
    logic [1:0] drive_mode;
    logic in_bank;
    logic out_bank;
    logic [1:0] blink_rate;
    logic blink_alt;
  } disp_cfg_t;

  localparam disp_cfg_t CFG_RST = '{default: '0};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_CMD = 4'h4,
    ST_DATA = 4'h8
  } parse_state_t;

endpackage

// ### core/lcd_cmd_decoder.sv
// Purpose: receive-only two-wire slave, command parser and RAM filler
// Assumes: scl_i clocks the bit sampler; all parsing runs on mclk_i
// Notes: sda/scl are open drain, output enable high pulls the line low
`timescale 1ns/100ps
module lcd_cmd_decoder #(
  parameter int unsigned PWR_STEP_CYCLES = 8
) (
  // system
  input wire logic mclk_i,
  input wire logic nrst_i,
  // serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  // straps
  input wire logic cluster_strap_pin_i,
  input wire logic subaddr_pin_0_i,
  input wire logic subaddr_pin_1_i,
  input wire logic subaddr_pin_2_i,
  // display RAM read port
  input wire logic [5:0] ram_rd_addr_i,
  output logic [3:0] ram_rd_data_o,
  // held settings and filler busy flag
  output lcdc_pkg::disp_cfg_t cfg_o,
  output logic [5:0] data_pointer_o,
  output logic [2:0] subaddr_cnt_o,
  output logic busy_o
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // highest bit index used per RAM location in each drive mode
  function automatic logic [1:0] loc_last(input logic [1:0] mode);
    case (mode)
      lcdc_pkg::MODE_STATIC: loc_last = 2'h0;
      lcdc_pkg::MODE_DUPLEX: loc_last = 2'h1;
      lcdc_pkg::MODE_TRIPLEX: loc_last = 2'h2;
      default: loc_last = 2'h3;
    endcase
  endfunction

  // bank switching exists only in static and 1:2 modes
  function automatic logic banked(input logic [1:0] mode);
    banked = (mode == lcdc_pkg::MODE_STATIC) || (mode == lcdc_pkg::MODE_DUPLEX);
  endfunction

  // ------------------------------------------------------------------
  // link domain: one sample per rising serial clock
  // ------------------------------------------------------------------
  logic link_bit;
  logic link_tog;

  // sample held for a whole clock period, so mclk may read it after the toggle syncs
  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_bit <= 1'b0;
      link_tog <= 1'b0;
    end else begin
      link_bit <= sda_i;
      link_tog <= ~link_tog;
    end
  end

  // ------------------------------------------------------------------
  // synchronisers into mclk
  // ------------------------------------------------------------------
  logic [1:0] tog_sync;
  logic tog_q;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic [1:0] strap_sync;
  logic [1:0] sub_sync_0;
  logic [1:0] sub_sync_1;
  logic [1:0] sub_sync_2;

  // two flops per pin; a third flop on the toggle, scl and sda feeds the edge detectors
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_sync <= 2'h0;
      tog_q <= 1'b0;
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap_sync <= 2'h0;
      sub_sync_0 <= 2'h0;
      sub_sync_1 <= 2'h0;
      sub_sync_2 <= 2'h0;
    end else begin
      tog_sync <= {tog_sync[0], link_tog};
      tog_q <= tog_sync[1];
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
      strap_sync <= {strap_sync[0], cluster_strap_pin_i};
      sub_sync_0 <= {sub_sync_0[0], subaddr_pin_0_i};
      sub_sync_1 <= {sub_sync_1[0], subaddr_pin_1_i};
      sub_sync_2 <= {sub_sync_2[0], subaddr_pin_2_i};
    end
  end

  logic bit_ev;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic [2:0] strap_sub;

  // bus events seen in the mclk domain
  assign bit_ev = tog_sync[1] ^ tog_q;
  assign start_det = scl_sync[1] && sda_q && !sda_sync[1];
  assign stop_det = scl_sync[1] && !sda_q && sda_sync[1];
  assign scl_fall = scl_q && !scl_sync[1];
  assign strap_sub = {sub_sync_2[1], sub_sync_1[1], sub_sync_0[1]};

  // ------------------------------------------------------------------
  // bit counter and byte assembly
  // ------------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [6:0] shreg;
  logic byte_done;
  logic [7:0] byte_val;

  assign byte_done = bit_ev && (bit_cnt == lcdc_pkg::LAST_DATA_BIT);
  assign byte_val = {shreg, link_bit};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt <= 4'h0;
      shreg <= 7'h00;
    end else if (start_det) begin
      bit_cnt <= 4'h0;
    end else if (bit_ev) begin
      shreg <= byte_val[6:0];
      bit_cnt <= (bit_cnt == lcdc_pkg::ACK_BIT) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // transfer parser
  // ------------------------------------------------------------------
  lcdc_pkg::parse_state_t state;
  lcdc_pkg::parse_state_t next_state;
  logic addr_ok;
  logic sub_match;
  logic [5:0] ptr;
  logic [2:0] sub_cnt;

  // address match with strap; write direction only
  assign addr_ok = (byte_val[7:2] == lcdc_pkg::SLAVE_ADDR_TOP) && (byte_val[1] == strap_sync[1]) && !byte_val[0];
  assign sub_match = (sub_cnt == strap_sub);

  always_comb begin
    next_state = state;
    case (state)
      lcdc_pkg::ST_ADDR: if (byte_done) next_state = addr_ok ? lcdc_pkg::ST_CMD : lcdc_pkg::ST_IDLE;
      lcdc_pkg::ST_CMD: if (byte_done) next_state = byte_val[lcdc_pkg::CONT_BIT] ? lcdc_pkg::ST_CMD : lcdc_pkg::ST_DATA;
      lcdc_pkg::ST_DATA: next_state = lcdc_pkg::ST_DATA;
      lcdc_pkg::ST_IDLE: next_state = lcdc_pkg::ST_IDLE;
      default: next_state = lcdc_pkg::ST_IDLE;
    endcase
    if (start_det) begin
      next_state = lcdc_pkg::ST_ADDR;
    end else if (stop_det) begin
      next_state = lcdc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= lcdc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // acknowledge
  // ------------------------------------------------------------------
  logic ack_pend;
  logic ack_drv;

  // choose to acknowledge at the eighth bit, drive in the low phase after
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_pend <= 1'b0;
      ack_drv <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_pend <= 1'b0;
      ack_drv <= 1'b0;
    end else if (byte_done) begin
      ack_pend <= (state == lcdc_pkg::ST_ADDR && addr_ok) || (state == lcdc_pkg::ST_CMD)
        || (state == lcdc_pkg::ST_DATA && sub_match);
    end else if (scl_fall) begin
      ack_drv <= ack_pend;
      ack_pend <= 1'b0;
    end
  end

  // only acknowledges ever leave the device
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_drv;

  // ------------------------------------------------------------------
  // command execution
  // ------------------------------------------------------------------
  logic cmd_ev;
  logic ptr_load;
  logic dev_sel;
  logic mode_set;
  logic bank_sel;
  logic blink_set;

  assign cmd_ev = byte_done && (state == lcdc_pkg::ST_CMD);
  assign ptr_load = cmd_ev && !byte_val[lcdc_pkg::CLASS_BIT];
  assign mode_set = cmd_ev && (byte_val[lcdc_pkg::OPC_TOP -: 2] == lcdc_pkg::OPC_MODE_SET);
  assign dev_sel = cmd_ev && (byte_val[lcdc_pkg::OPC_TOP -: 4] == lcdc_pkg::OPC_DEV_SEL);
  assign bank_sel = cmd_ev && (byte_val[lcdc_pkg::OPC_TOP -: 5] == lcdc_pkg::OPC_BANK);
  assign blink_set = cmd_ev && (byte_val[lcdc_pkg::OPC_TOP -: 4] == lcdc_pkg::OPC_BLINK);

  lcdc_pkg::disp_cfg_t cfg;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= lcdc_pkg::CFG_RST;
    end else if (mode_set) begin
      cfg.power_saving_sel <= byte_val[lcdc_pkg::PWR_BIT];
      cfg.display_en <= byte_val[lcdc_pkg::EN_BIT];
      cfg.bias_half <= byte_val[lcdc_pkg::BIAS_BIT];
      cfg.drive_mode <= byte_val[1:0];
    end else if (bank_sel && banked(cfg.drive_mode)) begin
      // banks move only in static and 1:2
      cfg.in_bank <= byte_val[lcdc_pkg::IN_BANK_BIT];
      cfg.out_bank <= byte_val[lcdc_pkg::OUT_BANK_BIT];
    end else if (blink_set) begin
      cfg.blink_rate <= byte_val[1:0];
      cfg.blink_alt <= byte_val[lcdc_pkg::ALT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // RAM filler: one RAM bit per step
  // ------------------------------------------------------------------
  logic [7:0] fill_sh;
  logic [3:0] fill_left;
  logic [$clog2(PWR_STEP_CYCLES + 1)-1:0] pace;
  logic [1:0] bit_pos;
  logic step;
  logic loc_end;
  logic fill_busy;

  assign fill_busy = (fill_left != 4'h0);
  assign step = fill_busy && (pace == '0);
  assign loc_end = (bit_pos == loc_last(cfg.drive_mode));

  // slow stepping in power saving stands in for the reduced internal clock
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fill_sh <= 8'h00;
      fill_left <= 4'h0;
      pace <= '0;
    end else if (byte_done && state == lcdc_pkg::ST_DATA) begin
      fill_sh <= byte_val;
      fill_left <= lcdc_pkg::BYTE_BITS;
      pace <= '0;
    end else if (fill_busy) begin
      if (step) begin
        fill_sh <= {fill_sh[6:0], 1'b0};
        fill_left <= fill_left - 4'h1;
        pace <= cfg.power_saving_sel ? ($bits(pace))'(PWR_STEP_CYCLES - 1) : '0;
      end else begin
        pace <= pace - 1'b1;
      end
    end
  end

  // pointer, bit position and subaddress counter
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr <= 6'h00;
      bit_pos <= 2'h0;
      sub_cnt <= 3'h0;
    end else if (ptr_load) begin
      ptr <= byte_val[5:0];
      bit_pos <= 2'h0;
    end else if (dev_sel) begin
      sub_cnt <= byte_val[2:0];
      bit_pos <= 2'h0;
    end else if (step) begin
      bit_pos <= loc_end ? 2'h0 : bit_pos + 2'h1;
      if (loc_end) begin
        ptr <= (ptr >= lcdc_pkg::LAST_LOC) ? 6'h00 : ptr + 6'h01;
        if (ptr >= lcdc_pkg::LAST_LOC) begin
          sub_cnt <= sub_cnt + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // display RAM
  // ------------------------------------------------------------------
  logic [3:0] ram [lcdc_pkg::RAM_DEPTH];
  logic [1:0] wr_bit;

  assign wr_bit = (banked(cfg.drive_mode) && cfg.in_bank) ? lcdc_pkg::HI_BANK_BASE + bit_pos : bit_pos;

  // storage blocked unless the counter names this device
  always_ff @(posedge mclk_i) begin
    if (step && sub_match && ptr <= lcdc_pkg::LAST_LOC) begin
      ram[ptr][wr_bit] <= fill_sh[7];
    end
  end

  // out-of-range read addresses return zero
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ram_rd_data_o <= 4'h0;
    end else begin
      ram_rd_data_o <= (ram_rd_addr_i <= lcdc_pkg::LAST_LOC) ? ram[ram_rd_addr_i] : 4'h0;
    end
  end

  // ------------------------------------------------------------------
  // clock stretching and status outputs
  // ------------------------------------------------------------------
  logic stretch;

  // grab the clock only once it is already low, never shortening a high phase
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stretch <= 1'b0;
    end else begin
      // drop together with the last stored bit, so the clock is never held past the work
      stretch <= fill_busy && !(step && fill_left == 4'h1) && cfg.power_saving_sel && (stretch || !scl_sync[1]);
    end
  end

  assign scl_o = 1'b0;
  assign scl_oe_o = stretch;
  assign cfg_o = cfg;
  assign data_pointer_o = ptr;
  assign subaddr_cnt_o = sub_cnt;
  assign busy_o = fill_busy;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  localparam int FILL_MAX = 8 * PWR_STEP_CYCLES + 8;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence addr_byte_ok;
    state == lcdc_pkg::ST_ADDR && byte_done && addr_ok && !start_det && !stop_det;
  endsequence
  sequence ack_window;
    ack_pend && scl_fall && !byte_done && !start_det && !stop_det;
  endsequence
  sequence fill_start;
    byte_done && state == lcdc_pkg::ST_DATA && !start_det && !stop_det;
  endsequence

  a_addr_ack_match: assert property (addr_byte_ok |=> ack_pend && state == lcdc_pkg::ST_CMD)
    else $error("matching address not acknowledged");
  a_foreign_ignored: assert property ((state == lcdc_pkg::ST_IDLE && !start_det) |=> state == lcdc_pkg::ST_IDLE && !ack_pend)
    else $error("ignored transfer left idle");
  a_ack_drive_low: assert property (ack_window |=> sda_oe_o [*2])
    else $error("acknowledge not driven");
  a_cont_flag_ends: assert property ((cmd_ev && !byte_val[lcdc_pkg::CONT_BIT] && !start_det && !stop_det)
    |=> state == lcdc_pkg::ST_DATA)
    else $error("last command did not enter data phase");
  a_cmd_ack_all: assert property ((cmd_ev && !start_det && !stop_det) |=> ack_pend)
    else $error("command byte not acknowledged");
  a_data_ack_sub: assert property (fill_start |=> ack_pend == $past(sub_match))
    else $error("display acknowledge ignores subaddress");
  a_mode_set_load: assert property (mode_set |=> cfg.drive_mode == $past(byte_val[1:0])
    && cfg.power_saving_sel == $past(byte_val[lcdc_pkg::PWR_BIT])
    && cfg.display_en == $past(byte_val[lcdc_pkg::EN_BIT])
    && cfg.bias_half == $past(byte_val[lcdc_pkg::BIAS_BIT]))
    else $error("mode-set fields not loaded");
  a_ptr_load_val: assert property (ptr_load |=> ptr == $past(byte_val[5:0]) && bit_pos == 2'h0)
    else $error("data pointer not loaded");
  a_bank_locked: assert property ((bank_sel && !banked(cfg.drive_mode)) |=> $stable(cfg.in_bank) && $stable(cfg.out_bank))
    else $error("bank changed in 1:3 or 1:4");
  a_ptr_wrap_sub: assert property ((step && loc_end && ptr == lcdc_pkg::LAST_LOC && !ptr_load && !dev_sel)
    |=> ptr == 6'h00 && sub_cnt == $past(sub_cnt) + 3'h1)
    else $error("pointer overflow mishandled");
  a_ptr_advance: assert property ((step && loc_end && ptr < lcdc_pkg::LAST_LOC && !ptr_load && !dev_sel)
    |=> ptr == $past(ptr) + 6'h01)
    else $error("pointer did not advance");
  a_fill_bounded: assert property (fill_start |-> ##[8:FILL_MAX] !fill_busy)
    else $error("display byte not stored in time");
  a_read_ignored: assert property ((state == lcdc_pkg::ST_ADDR && byte_done && byte_val[0] && !start_det)
    |=> state == lcdc_pkg::ST_IDLE && !ack_pend)
    else $error("read address not ignored");
  a_stretch_busy: assert property (scl_oe_o |-> fill_busy && cfg.power_saving_sel)
    else $error("clock held without pending work");

endmodule

// ### testbench/serial_master_model.sv
// Purpose: behavioural two-wire bus master that writes bytes to the decoder
// Assumes: open-drain lines, pull-up level when nobody pulls low
// Notes: scl stands still high between frames; half period 62.5 ns
`timescale 1ns/100ps
module serial_master_model (
  // line drive, high pulls the line low
  output logic scl_drv_low,
  output logic sda_drv_low,
  // resolved line levels
  input wire logic scl_line,
  input wire logic sda_line
);
  initial begin
    scl_drv_low = 1'b0;
    sda_drv_low = 1'b0;
  end

  // release scl and wait while a slave stretches it, bounded
  task automatic rise();
    int n;
    n = 0;
    scl_drv_low = 1'b0;
    while (scl_line !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  // start or repeated start
  task automatic start();
    #15 sda_drv_low = 1'b0;
    #47.5 rise();
    #62.5 sda_drv_low = 1'b1;
    #62.5 scl_drv_low = 1'b1;
  endtask

  task automatic stop();
    #15 sda_drv_low = 1'b1;
    #47.5 rise();
    #62.5 sda_drv_low = 1'b0;
    #62.5;
  endtask

  // byte msb first, data changes only while scl low, then ack slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #15 sda_drv_low = ~b[i];
      #47.5 rise();
      #62.5 scl_drv_low = 1'b1;
    end
    #15 sda_drv_low = 1'b0;
    #47.5 rise();
    #30 ack = ~sda_line;
    #32.5 scl_drv_low = 1'b1;
  endtask
endmodule

// ### testbench/lcd_cmd_decoder_tb_top.sv
// Purpose: self-checking bench of the serial command decoder
// Assumes: reference model tracks pointer, counter, settings and RAM
// Notes: random bytes come from an lfsr seeded with 32'he5f9
`timescale 1ns/100ps
module lcd_cmd_decoder_tb_top;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic strap = 1'b0;
  logic [2:0] sub = 3'h0;
  logic [5:0] rd_addr = 6'h00;
  logic sda_o, sda_oe_o, scl_o, scl_oe_o, busy_o, m_scl, m_sda, ack, stretch_seen;
  logic [3:0] ram_rd_data_o;
  lcdc_pkg::disp_cfg_t cfg_o, ec;
  logic [5:0] data_pointer_o, ep;
  logic [2:0] subaddr_cnt_o, es;
  logic [3:0] ram [40];
  logic [3:0] wm [40];
  logic [31:0] lfsr = 32'he5f9;
  int bad_count = 0;
  int tests_run = 0;
  int pos, phase;
  wire scl_line = ~(m_scl | scl_oe_o);
  wire sda_line = ~(m_sda | sda_oe_o);

  // ----------------------------------------------------------------
  // design, partner and clock
  // ----------------------------------------------------------------
  lcd_cmd_decoder #(.PWR_STEP_CYCLES(8)) lcd_cmd_decoder_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .cluster_strap_pin_i(strap), .subaddr_pin_0_i(sub[0]), .subaddr_pin_1_i(sub[1]),
    .subaddr_pin_2_i(sub[2]), .ram_rd_addr_i(rd_addr), .ram_rd_data_o(ram_rd_data_o),
    .cfg_o(cfg_o), .data_pointer_o(data_pointer_o), .subaddr_cnt_o(subaddr_cnt_o), .busy_o(busy_o));
  serial_master_model serial_master_model_i (
    .scl_drv_low(m_scl), .sda_drv_low(m_sda), .scl_line(scl_line), .sda_line(sda_line));

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  // stretch seen only counts once reset is released
  always @(posedge mclk_i) begin
    if (nrst_i && scl_oe_o === 1'b1) stretch_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // checking and reference model
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic mcmd(input logic [7:0] b);
    if (!b[6]) begin
      ep = b[5:0];
      pos = 0;
    end else if (b[6:5] == 2'b10) begin
      {ec.power_saving_sel, ec.display_en, ec.bias_half, ec.drive_mode} = b[4:0];
    end else if (b[6:3] == 4'b1100) begin
      es = b[2:0];
      pos = 0;
    end else if (b[6:3] == 4'b1110) begin
      {ec.blink_alt, ec.blink_rate} = b[2:0];
    end else if (b[6:2] == 5'b11110 && ec.drive_mode inside {2'h1, 2'h2}) begin
      {ec.in_bank, ec.out_bank} = b[1:0];
    end
  endtask

  // fill order, suppressed store, wrap and counter carry
  task automatic mdata(input logic [7:0] b);
    int n, base;
    n = (ec.drive_mode == 2'h0) ? 4 : ec.drive_mode;
    base = (ec.in_bank && ec.drive_mode inside {2'h1, 2'h2}) ? 2 : 0;
    for (int i = 7; i >= 0; i--) begin
      if (es == sub && ep < 40) begin
        ram[ep][base + pos] = b[i];
        wm[ep][base + pos] = 1'b1;
      end
      pos++;
      if (pos == n) begin
        pos = 0;
        if (ep >= 39) begin
          ep = 0;
          es++;
        end else ep++;
      end
    end
  endtask

  task automatic sta();
    phase = 0;
    serial_master_model_i.start();
  endtask

  // one byte on the bus, ack compared with the model's expectation
  task automatic send(input logic [7:0] b);
    logic e;
    serial_master_model_i.wbyte(b, ack);
    case (phase)
      0: begin
        e = (b[7:1] == {lcdc_pkg::SLAVE_ADDR_TOP, strap}) && !b[0];
        phase = e ? 1 : 3;
      end
      1: begin
        e = 1'b1;
        mcmd(b);
        phase = b[7] ? 1 : 2;
      end
      2: begin
        e = (es == sub);
        mdata(b);
      end
      default: e = 1'b0;
    endcase
    check(ack, e);
  endtask

  task automatic sto_chk(input string name);
    serial_master_model_i.stop();
    // settings, pointer, counter, idle filler, constant drive values
    check({cfg_o, data_pointer_o, subaddr_cnt_o, busy_o, sda_o, scl_o}, {ec, ep, es, 3'b000});
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    ec = lcdc_pkg::CFG_RST;
    ep = 6'h00;
    es = 3'h0;
    pos = 0;
    stretch_seen = 1'b0;
    for (int k = 0; k < 40; k++) wm[k] = 4'h0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i) nrst_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    for (int m = 0; m < 4; m++) begin
      sta();
      send(8'h70);
      send({3'b110, 1'b0, 1'b1, m[0], m[1:0]});
      send({2'b00, 6'(rnd() % 30)});
      repeat (3) send(rnd());
      sto_chk("modes");
    end
    // strap high: the other address answers, the usual one is refused
    @(negedge mclk_i) strap <= 1'b1;
    #200 sta();
    send(8'h70);
    sta();
    send(8'h72);
    send(8'h00);
    @(negedge mclk_i) strap <= 1'b0;
    #200 sta();
    send(8'h72);
    send(8'h00);
    sta();
    send(8'h71);
    send(8'hcf);
    sta();
    send(8'h70);
    send(8'h05);
    send(rnd());
    sta();
    send(8'h70);
    send(8'hfc);
    send(8'h4d);
    sto_chk("refusals");
    @(negedge mclk_i) sub <= 3'h3;
    #200 sta();
    send(8'h70);
    send(8'hcd);
    send(8'he2);
    send(8'h26);
    repeat (3) send(rnd());
    sto_chk("cascade");
    for (int r = 0; r < 8; r++) begin
      sta();
      send(8'h70);
      send({6'b110010, r[1:0]});
      send({6'b111110, r[2], ~r[0]});
      send({5'b11110, r[2:0]});
      send(8'h01);
      send(rnd());
      sto_chk("bank_blink");
    end
    sta();
    send(8'h70);
    send(8'hd9);
    send(8'he3);
    send(8'h00);
    repeat (2) send(rnd());
    sto_chk("power");
    // stretch while storing in power saving
    check(stretch_seen, 1'b1);
    for (int k = 0; k < 40; k++) begin
      @(negedge mclk_i) rd_addr <= 6'(k);
      repeat (2) @(posedge mclk_i);
      check(ram_rd_data_o & wm[k], ram[k] & wm[k]);
    end
    $display("test ram done");
    final_report();
  end

  // watchdog over the whole expected run
  initial begin
    #400000;
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
